/* File: shared/lcd_defs.svh */
// Purpose: Register map, field positions and reset values of the
//          frame address generator and shade lookup.
// Assumes: 32-bit register port with byte addresses.
// Notes:   Definitions only; included by bare name.
//
// Overview of operation
// - Bank field forms fetch address bits 28..22
// - Upper base gives upper counter start address
// - Dual scan loads lower counter from lower base
// - Single scan holds lower counter at lower base, unused
// - Base fields writable while video runs
// - Software avoids base changes near frame end
// - Line skip is halfword gap between lines
// - View width is halfwords fetched per line
// - Red code n picks nibble n of red table
// - Green code n picks nibble n of green table
// - Blue code n picks nibble n of blue table
`ifndef LCD_DEFS_SVH
`define LCD_DEFS_SVH

// ==========================================================
// Register byte addresses
`define UPPER_OFS     32'h14A0_0014
`define LOWER_OFS     32'h14A0_0018
`define GEOM_OFS      32'h14A0_001C
`define RED_OFS       32'h14A0_0020
`define GREEN_OFS     32'h14A0_0024
`define BLUE_OFS      32'h14A0_0028
`define CTRL_OFS      32'h14A0_0054
`define STAT_OFS      32'h14A0_0058

// ==========================================================
// Writable bit masks, reserved bits read zero
`define UPPER_MASK    32'h0FFF_FFFF
`define LOWER_MASK    32'h001F_FFFF
`define GEOM_MASK     32'h003F_FFFF
`define BLUE_MASK     32'h0000_FFFF
`define CTRL_MASK     32'h000F_FC03
`define REG_RESET     32'h0000_0000

// ==========================================================
// Field positions
`define BANK_HI       27
`define BANK_LO       21
`define BASE_HI       20
`define SKIP_HI       21
`define SKIP_LO       11
`define WIDTH_HI      10
`define EN_BIT        0
`define DUAL_BIT      1
`define LINES_LO      10
`define STAT_RUN_BIT  16

`endif

/* File: shared/lcd_pkg.sv */
// Purpose: Types and shared arithmetic of the frame address block.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   One-hot fetch states.
package lcd_pkg;

   // ==========================================================
   // Types
   typedef logic [20:0] hw_addr_t;  // Halfword address A[21:1]
   typedef logic [10:0] geom_t;     // Width or skip in halfwords

   typedef enum logic [4:0] {
      ST_IDLE     = 5'h01,
      ST_ISSUE_UP = 5'h02,
      ST_WAIT_UP  = 5'h04,
      ST_ISSUE_LO = 5'h08,
      ST_WAIT_LO  = 5'h10
   } fetch_state_t;

   // ==========================================================
   // Nibble n of a 32-bit table
   function automatic logic [3:0] pick_nibble(input logic [31:0] tbl,
                                              input logic [2:0]  code);
      return tbl[{code, 2'h0} +: 4];
   endfunction

endpackage

/* File: design/addr_counter.sv */
// Purpose: Halfword address counter for one panel half.
// Assumes: Load and step never matter in the same cycle; load wins.
// Notes:   Skip is added on the last halfword of a line.
`timescale 1ns/1ns
`default_nettype none
module addr_counter (
   input  wire logic             sys_clk_i,
   input  wire logic             rst_i,
   input  wire logic             load_i,
   input  wire lcd_pkg::hw_addr_t load_val_i,
   input  wire logic             step_i,
   input  wire logic             skip_en_i,
   input  wire lcd_pkg::geom_t   skip_i,
   output lcd_pkg::hw_addr_t     count_o
);
   import lcd_pkg::*;

   hw_addr_t count_ff;     // Current halfword address
   hw_addr_t nxt_count;    // Next halfword address
   hw_addr_t stride;       // One plus optional skip

   // ==========================================================
   // Step arithmetic
   assign stride = skip_en_i ? (hw_addr_t'(skip_i) + 21'h00_0001)
                             : 21'h00_0001;
   assign nxt_count = load_i ? load_val_i :
                      step_i ? hw_addr_t'(count_ff + stride)
                             : count_ff;

   // Counter register
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         count_ff <= 21'h00_0000;
      end else begin
         count_ff <= nxt_count;
      end
   end

   assign count_o = count_ff;

   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   a_load_takes_base:
      assert property (load_i |=> count_ff == $past(load_val_i))
      else $error("counter did not take its load value");
endmodule
`default_nettype wire

/* File: design/shade_lookup.sv */
// Purpose: Maps red, green and blue codes to sixteen-level shades.
// Assumes: Tables are stable while pixels flow.
// Notes:   One cycle of latency, valid travels with the shades.
`timescale 1ns/1ns
`default_nettype none
module shade_lookup (
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic        pix_valid_i,
   input  wire logic [2:0]  pix_red_i,
   input  wire logic [2:0]  pix_green_i,
   input  wire logic [1:0]  pix_blue_i,
   input  wire logic [31:0] red_tbl_i,
   input  wire logic [31:0] green_tbl_i,
   input  wire logic [15:0] blue_tbl_i,
   output logic             shade_valid_o,
   output logic [3:0]       shade_red_o,
   output logic [3:0]       shade_green_o,
   output logic [3:0]       shade_blue_o
);
   import lcd_pkg::*;

   logic [3:0] nxt_red;    // Red shade for this code
   logic [3:0] nxt_green;  // Green shade for this code
   logic [3:0] nxt_blue;   // Blue shade for this code

   // ==========================================================
   // Nibble selection
   assign nxt_red   = pick_nibble(red_tbl_i, pix_red_i);
   assign nxt_green = pick_nibble(green_tbl_i, pix_green_i);
   assign nxt_blue  = pick_nibble({16'h0000, blue_tbl_i},
                                  {1'b0, pix_blue_i});

   // Output registers
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         shade_valid_o <= 1'b0;
         shade_red_o   <= 4'h0;
         shade_green_o <= 4'h0;
         shade_blue_o  <= 4'h0;
      end else begin
         shade_valid_o <= pix_valid_i;
         shade_red_o   <= nxt_red;
         shade_green_o <= nxt_green;
         shade_blue_o  <= nxt_blue;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   a_red_nibble:
      assert property (pix_valid_i |=> shade_valid_o &&
         shade_red_o == $past(red_tbl_i[{pix_red_i, 2'h0} +: 4]))
      else $error("red shade differs from table nibble");
   a_green_nibble:
      assert property (pix_valid_i && pix_green_i == 3'h0 |=>
         shade_green_o == $past(green_tbl_i[3:0]))
      else $error("green code zero missed lowest nibble");
   a_blue_nibble:
      assert property (pix_valid_i && pix_blue_i == 2'h3 |=>
         shade_blue_o == $past(blue_tbl_i[15:12]))
      else $error("blue code three missed top nibble");
endmodule
`default_nettype wire

/* File: design/lcd_frame_addr.sv */
// Purpose: Frame buffer address generator with shade lookup tables.
// Assumes: Fetch sink handshakes with valid and ready on this clock.
// Notes:   Bases are taken at frame start only; writes while running
//          show on the next frame.
`timescale 1ns/1ns
`default_nettype none
`include "lcd_defs.svh"
module lcd_frame_addr #(
   parameter int LINE_W = 10
) (
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic [31:0] reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic [31:0]      reg_rdata_o,
   output logic             fetch_valid_o,
   output logic [28:0]      fetch_addr_o,
   output logic             fetch_lower_o,
   input  wire logic        fetch_ready_i,
   output logic             frame_start_o,
   input  wire logic        pix_valid_i,
   input  wire logic [2:0]  pix_red_i,
   input  wire logic [2:0]  pix_green_i,
   input  wire logic [1:0]  pix_blue_i,
   output logic             shade_valid_o,
   output logic [3:0]       shade_red_o,
   output logic [3:0]       shade_green_o,
   output logic [3:0]       shade_blue_o
);
   import lcd_pkg::*;

   // ==========================================================
   // Registers seen by software
   logic [31:0] upper_ff;      // frame_start_upper
   logic [31:0] lower_ff;      // frame_start_lower
   logic [31:0] geom_ff;       // virtual_screen_geometry
   logic [31:0] red_ff;        // red_shade_table
   logic [31:0] green_ff;      // green_shade_table
   logic [31:0] blue_ff;       // blue_shade_map
   logic [31:0] ctrl_ff;       // Enable, dual scan, line count
   logic [31:0] rdata_ff;      // Read data one cycle later

   // Decoded fields
   logic [6:0]        video_bank_bits;
   hw_addr_t          upper_base;
   hw_addr_t          lower_base;
   geom_t             line_skip_halfwords;
   geom_t             view_width_halfwords;
   logic [LINE_W-1:0] line_count_minus_one;
   logic              video_output_enable;
   logic              dual_scan;

   // Address decode and read mux
   logic        hit_upper;
   logic        hit_lower;
   logic        hit_geom;
   logic        hit_red;
   logic        hit_green;
   logic        hit_blue;
   logic        hit_ctrl;
   logic        hit_stat;
   logic [31:0] status_word;
   logic [31:0] rd_mux;

   // Fetch sequencing
   fetch_state_t      state_ff;
   fetch_state_t      nxt_state;
   geom_t             word_ff;        // Halfword index in line
   logic [LINE_W-1:0] current_line_counter;
   hw_addr_t          upper_cnt;
   hw_addr_t          lower_cnt;
   logic              valid_ff;
   logic [28:0]       addr_ff;
   logic              lower_sel_ff;
   logic              frame_start_ff;
   logic              accept;
   logic              take_up;
   logic              take_lo;
   logic              pos_done;
   logic              word_last;
   logic              line_last;
   logic              frame_last;
   logic              load;
   logic              step;

   // ==========================================================
   // Register port decode
   assign hit_upper = reg_addr_i == `UPPER_OFS;
   assign hit_lower = reg_addr_i == `LOWER_OFS;
   assign hit_geom  = reg_addr_i == `GEOM_OFS;
   assign hit_red   = reg_addr_i == `RED_OFS;
   assign hit_green = reg_addr_i == `GREEN_OFS;
   assign hit_blue  = reg_addr_i == `BLUE_OFS;
   assign hit_ctrl  = reg_addr_i == `CTRL_OFS;
   assign hit_stat  = reg_addr_i == `STAT_OFS;

   // Field extraction
   assign video_bank_bits      = upper_ff[`BANK_HI:`BANK_LO];
   assign upper_base           = upper_ff[`BASE_HI:0];
   assign lower_base           = lower_ff[`BASE_HI:0];
   assign line_skip_halfwords  = geom_ff[`SKIP_HI:`SKIP_LO];
   assign view_width_halfwords = geom_ff[`WIDTH_HI:0];
   assign line_count_minus_one = ctrl_ff[`LINES_LO +: LINE_W];
   assign video_output_enable  = ctrl_ff[`EN_BIT];
   assign dual_scan            = ctrl_ff[`DUAL_BIT];

   // Status shows the line under fetch and running state
   assign status_word = {15'h0000, ~state_ff[0],
                         {(16 - LINE_W){1'b0}}, current_line_counter};

   // Read selection, unmapped addresses read zero
   assign rd_mux = hit_upper ? upper_ff :
                   hit_lower ? lower_ff :
                   hit_geom  ? geom_ff  :
                   hit_red   ? red_ff   :
                   hit_green ? green_ff :
                   hit_blue  ? blue_ff  :
                   hit_ctrl  ? ctrl_ff  :
                   hit_stat  ? status_word : 32'h0000_0000;

   // Register writes, accepted at any time
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         upper_ff <= `REG_RESET;
         lower_ff <= `REG_RESET;
         geom_ff  <= `REG_RESET;
         red_ff   <= `REG_RESET;
         green_ff <= `REG_RESET;
         blue_ff  <= `REG_RESET;
         ctrl_ff  <= `REG_RESET;
      end else if (reg_wr_i) begin
         // Bases change even while running, for scrolling
         if (hit_upper) upper_ff <= reg_wdata_i & `UPPER_MASK;
         if (hit_lower) lower_ff <= reg_wdata_i & `LOWER_MASK;
         if (hit_geom)  geom_ff  <= reg_wdata_i & `GEOM_MASK;
         if (hit_red)   red_ff   <= reg_wdata_i;
         if (hit_green) green_ff <= reg_wdata_i;
         if (hit_blue)  blue_ff  <= reg_wdata_i & `BLUE_MASK;
         if (hit_ctrl)  ctrl_ff  <= reg_wdata_i & `CTRL_MASK;
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rdata_ff <= 32'h0000_0000;
      end else begin
         rdata_ff <= reg_rd_i ? rd_mux : 32'h0000_0000;
      end
   end

   // ==========================================================
   // Fetch handshake and position tracking
   assign accept    = valid_ff & fetch_ready_i;
   assign take_up   = accept & (state_ff == ST_WAIT_UP);
   assign take_lo   = accept & (state_ff == ST_WAIT_LO);
   // A position ends after the upper fetch, or the lower in dual scan
   assign pos_done  = dual_scan ? take_lo : take_up;
   assign word_last = word_ff == geom_t'(view_width_halfwords - 11'h001);
   assign line_last = current_line_counter == line_count_minus_one;
   assign frame_last = pos_done & word_last & line_last;
   // Bases are sampled only here, so the prefetch sees one frame
   assign load = video_output_enable &
                 ((state_ff == ST_IDLE) | frame_last);
   assign step = pos_done & ~frame_last;

   // Next state
   always_comb begin
      case (state_ff)
         ST_IDLE: begin
            nxt_state = video_output_enable ? ST_ISSUE_UP : ST_IDLE;
         end
         ST_ISSUE_UP: begin
            nxt_state = ST_WAIT_UP;
         end
         ST_WAIT_UP: begin
            if (!accept) begin
               nxt_state = ST_WAIT_UP;
            end else if (dual_scan) begin
               nxt_state = ST_ISSUE_LO;
            end else begin
               nxt_state = video_output_enable ? ST_ISSUE_UP : ST_IDLE;
            end
         end
         ST_ISSUE_LO: begin
            nxt_state = ST_WAIT_LO;
         end
         ST_WAIT_LO: begin
            if (!accept) begin
               nxt_state = ST_WAIT_LO;
            end else begin
               nxt_state = video_output_enable ? ST_ISSUE_UP : ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // State register
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Halfword and line position within the frame
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || load) begin
         word_ff              <= 11'h000;
         current_line_counter <= '0;
      end else if (step && word_last) begin
         word_ff              <= 11'h000;
         current_line_counter <= current_line_counter + 1'b1;
      end else if (step) begin
         word_ff              <= word_ff + 11'h001;
      end
   end

   // Fetch request registers
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         valid_ff       <= 1'b0;
         addr_ff        <= 29'h0000_0000;
         lower_sel_ff   <= 1'b0;
         frame_start_ff <= 1'b0;
      end else begin
         frame_start_ff <= load;
         if (state_ff == ST_ISSUE_UP) begin
            valid_ff     <= 1'b1;
            addr_ff      <= {video_bank_bits, upper_cnt, 1'b0};
            lower_sel_ff <= 1'b0;
         end else if (state_ff == ST_ISSUE_LO) begin
            valid_ff     <= 1'b1;
            addr_ff      <= {video_bank_bits, lower_cnt, 1'b0};
            lower_sel_ff <= 1'b1;
         end else if (accept) begin
            valid_ff     <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Address counters for the two panel halves
   addr_counter u_upper (
      .sys_clk_i  (sys_clk_i),
      .rst_i      (rst_i),
      .load_i     (load),
      .load_val_i (upper_base),
      .step_i     (step),
      .skip_en_i  (word_last),
      .skip_i     (line_skip_halfwords),
      .count_o    (upper_cnt)
   );

   // In single scan the lower counter holds the lower base and is never fetched
   addr_counter u_lower (
      .sys_clk_i  (sys_clk_i),
      .rst_i      (rst_i),
      .load_i     (load),
      .load_val_i (lower_base),
      .step_i     (step & dual_scan),
      .skip_en_i  (word_last),
      .skip_i     (line_skip_halfwords),
      .count_o    (lower_cnt)
   );

   // Shade tables
   shade_lookup u_shade (
      .sys_clk_i     (sys_clk_i),
      .rst_i         (rst_i),
      .pix_valid_i   (pix_valid_i),
      .pix_red_i     (pix_red_i),
      .pix_green_i   (pix_green_i),
      .pix_blue_i    (pix_blue_i),
      .red_tbl_i     (red_ff),
      .green_tbl_i   (green_ff),
      .blue_tbl_i    (blue_ff[15:0]),
      .shade_valid_o (shade_valid_o),
      .shade_red_o   (shade_red_o),
      .shade_green_o (shade_green_o),
      .shade_blue_o  (shade_blue_o)
   );

   // Outputs
   assign reg_rdata_o   = rdata_ff;
   assign fetch_valid_o = valid_ff;
   assign fetch_addr_o  = addr_ff;
   assign fetch_lower_o = lower_sel_ff;
   assign frame_start_o = frame_start_ff;

   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_gap_then_lower;
      !fetch_valid_o ##1 (fetch_valid_o && fetch_lower_o);
   endsequence

   sequence s_single_take;
      take_up && !dual_scan && video_output_enable;
   endsequence

   a_bank_in_addr:
      assert property ($rose(fetch_valid_o) |->
         fetch_addr_o[28:22] == $past(upper_ff[`BANK_HI:`BANK_LO]))
      else $error("fetch bank bits differ from bank field");
   a_frame_from_base:
      assert property (frame_start_o |-> ##1 (fetch_valid_o &&
         !fetch_lower_o && fetch_addr_o[21:1] == $past(upper_base, 2)))
      else $error("first fetch of frame not at upper base");
   a_lower_follows:
      assert property (take_up && dual_scan |-> ##1 s_gap_then_lower)
      else $error("lower half fetch did not follow upper");
   a_step_one:
      assert property ((s_single_take and !word_last) |-> ##2
         (fetch_addr_o[21:1] == $past(fetch_addr_o[21:1], 2) + 21'h00_0001))
      else $error("address did not advance by one halfword");
   a_line_skip:
      assert property ((s_single_take and word_last && !line_last) |-> ##2
         (fetch_addr_o[21:1] == $past(fetch_addr_o[21:1], 2) + 21'h00_0001
          + hw_addr_t'($past(line_skip_halfwords, 2))))
      else $error("line skip not applied at line end");
   a_scroll_write:
      assert property (reg_wr_i && hit_upper && !state_ff[0] |=>
         upper_base == $past(reg_wdata_i[20:0]))
      else $error("base write lost while running");
   a_read_status:
      assert property (reg_rd_i && hit_stat |=>
         reg_rdata_o[LINE_W-1:0] == $past(current_line_counter))
      else $error("status read lost current line");
endmodule
`default_nettype wire

/* File: verif/fetch_sink.sv */
// Purpose: Fetch sink that stands in for the panel data path.
// Assumes: Valid/ready handshake on the system clock.
// Notes:   Slow mode accepts one request in every four cycles.
`timescale 1ns/1ns
`default_nettype none
module fetch_sink (
   input  wire logic sys_clk_i,
   input  wire logic rst_i,
   input  wire logic slow_i,
   output logic      ready_o
);
   // ==========================================================
   // Ready pacing
   logic [1:0] tick_ff;  // Stall phase counter

   // Free-running phase, cleared by reset
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         tick_ff <= 2'h0;
      end else begin
         tick_ff <= tick_ff + 2'h1;
      end
   end

   // Prompt: always ready; slow: one cycle in four
   assign ready_o = !rst_i && (!slow_i || tick_ff == 2'h3);
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Purpose: Self-checking bench of the frame address and shade block.
// Assumes: Fetch sink model paces the fetch handshake.
// Notes:   Each fetch run resets the block and programs it afresh.
`timescale 1ns/1ns
`default_nettype none
`include "lcd_defs.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module tb_top;
   import lcd_pkg::*;
   // ==========================================================
   // Signals and constants
   logic        sys_clk_i     = 1'b0;
   logic        rst_i         = 1'b1;
   logic [31:0] reg_addr_i    = 32'h0;
   logic [31:0] reg_wdata_i   = 32'h0;
   logic        reg_wr_i      = 1'b0;
   logic        reg_rd_i      = 1'b0;
   logic        pix_valid_i   = 1'b0;
   logic [2:0]  pix_red_i     = 3'h0;
   logic [2:0]  pix_green_i   = 3'h0;
   logic [1:0]  pix_blue_i    = 2'h0;
   logic        slow          = 1'b0;
   logic [31:0] reg_rdata_o;
   logic        fetch_valid_o;
   logic [28:0] fetch_addr_o;
   logic        fetch_lower_o;
   logic        fetch_ready_i;
   logic        frame_start_o;
   logic        shade_valid_o;
   logic [3:0]  shade_red_o;
   logic [3:0]  shade_green_o;
   logic [3:0]  shade_blue_o;
   int          bad_count     = 0;
   int          total_checks  = 0;
   int          cycles        = 0;
   logic [29:0] acc_q[$];      // Accepted {lower, address}
   logic [31:0] d;
   localparam logic [6:0]  BANK = 7'h31;
   localparam logic [20:0] UB   = 21'h80000;
   localparam logic [20:0] LB   = UB + 21'd10;  // Base + (3 + 2) * 2 lines
   localparam logic [20:0] UB2  = UB + 21'h40;
   localparam logic [31:0] ADR [5] = '{`UPPER_OFS, `LOWER_OFS, `GEOM_OFS, `RED_OFS, `GREEN_OFS};
   localparam logic [31:0] MSK [5] = '{`UPPER_MASK, `LOWER_MASK, `GEOM_MASK, 32'hFFFF_FFFF,
                                       32'hFFFF_FFFF};
   // Rows: {red, green, blue codes, expected red, green, blue shades}
   localparam logic [19:0] ROWS [8] = '{20'h1C815, 20'h3993A, 20'h56A53, 20'h73B7C,
                                        20'h8CC95, 20'hA9DBA, 20'hC6ED3, 20'hE3FFC};

   // ==========================================================
   // Instances, clock, monitor, timeout
   lcd_frame_addr #(.LINE_W(10)) lcd_frame_addr_inst (.sys_clk_i, .rst_i, .reg_addr_i,
      .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .fetch_valid_o, .fetch_addr_o,
      .fetch_lower_o, .fetch_ready_i, .frame_start_o, .pix_valid_i, .pix_red_i,
      .pix_green_i, .pix_blue_i, .shade_valid_o, .shade_red_o, .shade_green_o,
      .shade_blue_o);
   fetch_sink fetch_sink_inst (.sys_clk_i, .rst_i, .slow_i(slow), .ready_o(fetch_ready_i));

   // 125 MHz clock
   initial begin
      forever #4 sys_clk_i = ~sys_clk_i;
   end

   // Record every accepted fetch
   always @(posedge sys_clk_i) begin
      if (fetch_valid_o === 1'b1 && fetch_ready_i) acc_q.push_back({fetch_lower_o, fetch_addr_o});
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         complete_run();
      end
   end

   // ==========================================================
   // Bus tasks
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= v;
      reg_wr_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i <= 1'b0;
   endtask

   task automatic rd(input logic [31:0] a);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_i <= 1'b0;
      #1 d = reg_rdata_o;
   endtask

   // Bounded wait for n accepted fetches
   task automatic wait_acc(input int n);
      for (int i = 0; i < 400 && acc_q.size() < n; i++) @(posedge sys_clk_i);
      `CHK(acc_q.size() >= n, 1'b1)
   endtask

   // Program two lines of three halfwords, skip two, then compare
   task automatic run(input logic dual);
      int j;
      logic [20:0] e;
      @(posedge sys_clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      slow <= dual;
      wr(`UPPER_OFS, {4'h0, BANK, UB});
      wr(`LOWER_OFS, {11'h0, LB});
      wr(`GEOM_OFS, {10'h0, 11'd2, 11'd3});
      acc_q.delete();
      wr(`CTRL_OFS, 32'h400 | {30'h0, dual, 1'b1});
      wait_acc(8);
      for (int k = 0; k < 8; k++) begin
         j = dual ? k / 2 : k;
         e = ((dual && k[0]) ? LB : UB) + 21'((j % 6) / 3 * 5 + j % 3);
         `CHK(acc_q[k], {dual & k[0], BANK, e, 1'b0})
      end
   endtask

   // Single exit point with counts and verdict
   task automatic complete_run();
      $display("Checks %0d, errors %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (10) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      // Reset values, then reserved bits masked
      for (int i = 0; i < 5; i++) begin
         rd(ADR[i]);
         `CHK(d, `REG_RESET)
         wr(ADR[i], 32'hFFFF_FFFF);
         rd(ADR[i]);
         `CHK(d, MSK[i])
      end
      // Unmapped word ignores writes, reads zero
      wr(32'h14A0_002C, 32'hFFFF_FFFF);
      rd(32'h14A0_002C);
      `CHK(d, 32'h0)
      // Status while idle: not running, line zero
      rd(`STAT_OFS);
      `CHK(d, 32'h0)
      wr(`RED_OFS, 32'hFEDC_BA98);
      wr(`GREEN_OFS, 32'h1357_9BDF);
      wr(`BLUE_OFS, 32'h0000_C3A5);
      // Back-to-back pixel rows
      for (int i = 0; i <= 8; i++) begin
         @(posedge sys_clk_i);
         pix_valid_i <= (i < 8);
         if (i < 8) {pix_red_i, pix_green_i, pix_blue_i} <= ROWS[i][19:12];
         #1;
         if (i > 0) `CHK({shade_valid_o, shade_red_o, shade_green_o, shade_blue_o}, {1'b1, ROWS[i-1][11:0]})
      end
      @(posedge sys_clk_i);
      #1 `CHK(shade_valid_o, 1'b0)
      run(1'b1);
      run(1'b0);
      // Scroll while running; new base shows at next frame
      wr(`UPPER_OFS, {4'h0, BANK, UB2});
      repeat (2) @(posedge sys_clk_i);
      #1;
      for (int i = 0; i < 300 && frame_start_o !== 1'b1; i++) begin
         @(posedge sys_clk_i);
         #1;
      end
      acc_q.delete();
      wait_acc(1);
      `CHK(acc_q[0], {1'b0, BANK, UB2, 1'b0})
      // Status while fetching shows the running bit
      rd(`STAT_OFS);
      `CHK(d[`STAT_RUN_BIT], 1'b1)
      complete_run();
   end
endmodule
`default_nettype wire
